// File: hdl/baud_gen_device.sv
`timescale 1ns/1ps
`default_nettype none
module baud_gen_device #(
    parameter int PRESCALE_W = 5
) (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    baud_gen_if.device regs,
    input  wire logic timer_output_source_i,
    input  wire logic transmit_enable_bit_i,
    input  wire logic receive_enable_bit_i,
    input  wire logic serial_tx_a_i,
    input  wire logic serial_tx_b_i,
    input  wire logic general_port_line_i,
    output logic      base_clk_tick_o,
    output logic      baud_tick_o,
    output logic      baud_clk_o,
    output logic      tx_enable_sync_o,
    output logic      rx_enable_sync_o,
    output logic      divisor_illegal_o,
    output logic      shared_pin_o
);

    // *****************************************************************
    // Registers
    // *****************************************************************
    logic [7:0] baud_clock_control_r;
    logic [7:0] tx_pin_function_select_r;
    wire        sel_baud = (regs.addr == baud_gen_pkg::BAUD_CLOCK_CONTROL_OFS);
    wire        sel_pin  = (regs.addr == baud_gen_pkg::TX_PIN_FUNCTION_SELECT_OFS);

    // Write decode; writes keep only the implemented bits
    wire       wr_baud     = regs.wr & sel_baud;
    wire       wr_pin      = regs.wr & sel_pin;
    wire [7:0] baud_wr_val =
        regs.wdata & baud_gen_pkg::BAUD_CLOCK_CONTROL_MSK;
    wire [7:0] pin_wr_val  =
        regs.wdata & baud_gen_pkg::TX_PIN_FUNCTION_SELECT_MSK;

    // Masked values land on the edge that sees the write strobe
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            baud_clock_control_r     <= baud_gen_pkg::BAUD_CLOCK_CONTROL_RST;
            tx_pin_function_select_r <= baud_gen_pkg::TX_PIN_FUNCTION_SELECT_RST;
        end else begin
            if (wr_baud)
                baud_clock_control_r <= baud_wr_val;
            if (wr_pin)
                tx_pin_function_select_r <= pin_wr_val;
        end
    end

    // Unmapped addresses read zero; reads have no side effect, so the
    // read strobe is not needed here
    assign regs.rdata = sel_baud ? baud_clock_control_r
                      : sel_pin  ? tx_pin_function_select_r : 8'h00;

    wire [1:0] base_sel = baud_clock_control_r[baud_gen_pkg::BASE_SEL_LSB +: 2];
    wire [4:0] divisor  = baud_clock_control_r[baud_gen_pkg::DIVISOR_LSB +: 5];

    // *****************************************************************
    // Timer input synchroniser and edge detect
    // *****************************************************************
    // Timer output is taken straight from the timer, not its pin
    // A level counts only once two stages agree, so a runt pulse on
    // the timer line cannot make a false base tick
    logic [2:0] tmr_sync_r;
    logic       tmr_level_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tmr_sync_r  <= 3'h0;
            tmr_level_r <= 1'b0;
        end else begin
            tmr_sync_r <= {tmr_sync_r[1:0], timer_output_source_i};
            if (tmr_sync_r[1] == tmr_sync_r[2])
                tmr_level_r <= tmr_sync_r[2];
        end
    end
    wire tmr_rise = (tmr_sync_r[1] == tmr_sync_r[2]) & tmr_sync_r[2]
                  & ~tmr_level_r;

    // *****************************************************************
    // Prescaler and base clock select
    // *****************************************************************
    // Free running: a selector change needs no restart, but the first
    // tick after it may come early by up to one base period
    logic [PRESCALE_W-1:0] pre_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end

    // Ticks as the prescaler wraps its low 1, 3 or 5 bits
    logic base_tick;
    always_comb begin
        case (base_sel)
            baud_gen_pkg::SEL_TIMER: base_tick = tmr_rise;
            baud_gen_pkg::SEL_DIV2:  base_tick = &pre_r[0:0];
            baud_gen_pkg::SEL_DIV8:  base_tick = &pre_r[2:0];
            baud_gen_pkg::SEL_DIV32: base_tick = &pre_r[4:0];
            default:                 base_tick = 1'b0;
        endcase
    end

    // *****************************************************************
    // Five-bit divider and halving stage
    // *****************************************************************
    // An illegal divisor stops the counter rather than run too fast
    // Lowering k below the running count wraps at once instead of
    // running round all 32 states
    wire        div_bad = (divisor < baud_gen_pkg::DIVISOR_MIN);
    logic [4:0] div_cnt_r;
    logic       half_r;
    wire        div_wrap = base_tick & ~div_bad
                         & (div_cnt_r >= divisor - 5'h01);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt_r <= 5'h00;
            half_r    <= 1'b0;
        end else begin
            if (div_bad)
                div_cnt_r <= 5'h00;
            else if (base_tick)
                div_cnt_r <= div_wrap ? 5'h00 : div_cnt_r + 5'h01;
            if (div_wrap)
                half_r <= ~half_r;
        end
    end

    // *****************************************************************
    // Enable synchronisation to the base clock
    // *****************************************************************
    // Two base clocks pass before an enable change reaches the engine
    logic [1:0] txe_r;
    logic [1:0] rxe_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            txe_r <= 2'h0;
            rxe_r <= 2'h0;
        end else if (base_tick) begin
            txe_r <= {txe_r[0], transmit_enable_bit_i};
            rxe_r <= {rxe_r[0], receive_enable_bit_i};
        end
    end

    // *****************************************************************
    // Next values of the registered outputs
    // *****************************************************************
    // One baud tick per full period of the halved clock, taken at the
    // wrap that ends its high half
    wire base_clk_tick_nxt = base_tick;
    wire baud_tick_nxt     = div_wrap & half_r;
    wire baud_clk_nxt      = half_r;
    wire tx_en_nxt         = txe_r[1];
    wire rx_en_nxt         = rxe_r[1];
    wire div_bad_nxt       = div_bad;

    // *****************************************************************
    // Registered outputs and pin routing
    // *****************************************************************
    // Both lines idle high, so the AND lets whichever port is active
    // drive the pin; two ports sending at once would garble it
    wire tx_any = serial_tx_a_i & serial_tx_b_i; // Idle-high lines AND'ed
    wire pin_nxt = tx_pin_function_select_r[baud_gen_pkg::TX_ROUTE_BIT]
                 ? tx_any : general_port_line_i;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            base_clk_tick_o   <= 1'b0;
            baud_tick_o       <= 1'b0;
            baud_clk_o        <= 1'b0;
            tx_enable_sync_o  <= 1'b0;
            rx_enable_sync_o  <= 1'b0;
            divisor_illegal_o <= 1'b0;
            shared_pin_o      <= 1'b0;
        end else begin
            base_clk_tick_o   <= base_clk_tick_nxt;
            baud_tick_o       <= baud_tick_nxt;
            baud_clk_o        <= baud_clk_nxt;
            tx_enable_sync_o  <= tx_en_nxt;
            rx_enable_sync_o  <= rx_en_nxt;
            divisor_illegal_o <= div_bad_nxt;
            shared_pin_o      <= pin_nxt;
        end
    end

endmodule
`default_nettype wire

// File: hdl/baud_gen_pkg.sv
package baud_gen_pkg;

    // *****************************************************************
    // Register map of the device end
    // *****************************************************************
    localparam logic [15:0] TX_PIN_FUNCTION_SELECT_OFS = 16'hff20;
    localparam logic [15:0] BAUD_CLOCK_CONTROL_OFS     = 16'hff71;
    localparam logic [7:0]  TX_PIN_FUNCTION_SELECT_RST = 8'h00;
    localparam logic [7:0]  BAUD_CLOCK_CONTROL_RST     = 8'h1f;
    localparam logic [7:0]  TX_PIN_FUNCTION_SELECT_MSK = 8'h08;
    localparam logic [7:0]  BAUD_CLOCK_CONTROL_MSK     = 8'hdf;

    // Field positions
    localparam int BASE_SEL_LSB   = 6;
    localparam int DIVISOR_LSB    = 0;
    localparam int TX_ROUTE_BIT   = 3;

    // Base clock selector codes
    localparam logic [1:0] SEL_TIMER = 2'h0;
    localparam logic [1:0] SEL_DIV2  = 2'h1;
    localparam logic [1:0] SEL_DIV8  = 2'h2;
    localparam logic [1:0] SEL_DIV32 = 2'h3;

    // Least legal divisor and the bit-rate halving
    localparam logic [4:0] DIVISOR_MIN  = 5'h08;
    localparam int         BAUD_HALVING = 2;

    // Least gap between clearing and setting an enable, in base clocks
    localparam int ENABLE_GAP_BASE_CLKS = 2;

    // *****************************************************************
    // Avalon offsets of the controller's own registers (word index)
    // *****************************************************************
    localparam logic [3:0] CTL_ADDR_OFS    = 4'h0;
    localparam logic [3:0] CTL_WDATA_OFS   = 4'h1;
    localparam logic [3:0] CTL_CMD_OFS     = 4'h2;
    localparam logic [3:0] CTL_STATUS_OFS  = 4'h3;
    localparam logic [3:0] CTL_RDATA_OFS   = 4'h4;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_WRITE,
        CMD_READ
    } cmd_e;

endpackage

// File: hdl/baud_gen_if.sv
`timescale 1ns/1ps
`default_nettype none
// Register port of the device: one-cycle strobes, read data combinational
interface baud_gen_if;
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport device (
        input  addr,
        input  wr,
        input  rd,
        input  wdata,
        output rdata
    );
    modport host (
        output addr,
        output wr,
        output rd,
        output wdata,
        input  rdata
    );
endinterface
`default_nettype wire

// File: hdl/baud_gen_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host end: software posts a register access through Avalon registers,
// the host performs it on the device port and holds off writes that
// would break the programming order of the serial port.
module baud_gen_host (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        power_enable_i,
    input  wire logic        transmit_enable_bit_i,
    input  wire logic        receive_enable_bit_i,
    baud_gen_if.host         regs
);

    // *****************************************************************
    // Command registers
    // *****************************************************************
    logic [15:0] addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    logic        busy_r;
    logic        refused_r;
    logic        ack_r;
    baud_gen_pkg::cmd_e cmd_r;

    // Divisor needs both enables low, selector needs power low
    wire div_locked = transmit_enable_bit_i | receive_enable_bit_i;
    wire sel_locked = power_enable_i;
    wire to_baud = (addr_r == baud_gen_pkg::BAUD_CLOCK_CONTROL_OFS);
    wire [7:0] cur  = regs.rdata;
    wire bad_write = to_baud & (
        ((wdata_r[4:0] != cur[4:0]) & div_locked) |
        ((wdata_r[7:6] != cur[7:6]) & sel_locked));
    wire access = (avs_read_i | avs_write_i) & ~ack_r;
    // A write takes effect only at the edge where waitrequest is low
    wire take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    wire go = avs_write_i & take
            & (avs_address_i == baud_gen_pkg::CTL_CMD_OFS);

    // Device strobes are single cycles issued from cmd_r
    assign regs.addr  = addr_r;
    assign regs.wdata = wdata_r;
    assign regs.wr    = (cmd_r == baud_gen_pkg::CMD_WRITE) & ~bad_write;
    assign regs.rd    = (cmd_r == baud_gen_pkg::CMD_READ);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_r    <= 16'h0000;
            wdata_r   <= 8'h00;
            rdata_r   <= 8'h00;
            busy_r    <= 1'b0;
            refused_r <= 1'b0;
            cmd_r     <= baud_gen_pkg::CMD_NONE;
        end else begin
            case (cmd_r)
                baud_gen_pkg::CMD_WRITE: begin
                    refused_r <= bad_write;
                    busy_r    <= 1'b0;
                end
                baud_gen_pkg::CMD_READ: begin
                    rdata_r <= regs.rdata;
                    busy_r  <= 1'b0;
                end
                default: ;
            endcase
            cmd_r <= baud_gen_pkg::CMD_NONE;
            if (avs_write_i & take) begin
                if (avs_address_i == baud_gen_pkg::CTL_ADDR_OFS)
                    addr_r <= avs_writedata_i[15:0];
                if (avs_address_i == baud_gen_pkg::CTL_WDATA_OFS)
                    wdata_r <= avs_writedata_i[7:0];
            end
            if (go & ~busy_r & (avs_writedata_i[1:0] != 2'h0)) begin
                busy_r <= 1'b1;
                cmd_r  <= avs_writedata_i[0] ? baud_gen_pkg::CMD_WRITE
                                             : baud_gen_pkg::CMD_READ;
            end
        end
    end

    // *****************************************************************
    // Avalon slave: one wait cycle, answer on the second
    // *****************************************************************
    logic [31:0] rd_nxt;
    always_comb begin
        case (avs_address_i)
            baud_gen_pkg::CTL_ADDR_OFS:   rd_nxt = {16'h0000, addr_r};
            baud_gen_pkg::CTL_WDATA_OFS:  rd_nxt = {24'h000000, wdata_r};
            baud_gen_pkg::CTL_STATUS_OFS: rd_nxt = {30'h0, refused_r, busy_r};
            baud_gen_pkg::CTL_RDATA_OFS:  rd_nxt = {24'h000000, rdata_r};
            default:                      rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r             <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            ack_r             <= access;
            avs_waitrequest_o <= ~access;
            if (access & avs_read_i)
                avs_readdata_o <= rd_nxt;
        end
    end

endmodule
`default_nettype wire

// File: test/baud_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Watcher of the register port between the two ends
// ****************************************************
module baud_gen_properties (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] addr,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  rdata
);
    localparam logic [7:0] PMSK = baud_gen_pkg::TX_PIN_FUNCTION_SELECT_MSK;
    localparam logic [7:0] BMSK = baud_gen_pkg::BAUD_CLOCK_CONTROL_MSK;
    logic [7:0] pin_r;
    logic [7:0] baud_r;
    logic       pin_seen_r;
    logic       baud_seen_r;
    wire logic  pin_hit = addr == baud_gen_pkg::TX_PIN_FUNCTION_SELECT_OFS;
    wire logic  baud_hit = addr == baud_gen_pkg::BAUD_CLOCK_CONTROL_OFS;

    // Shadows so a read can be judged against the last write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {pin_seen_r, pin_r} <= 9'h000;
        end else if (wr && pin_hit) begin
            {pin_seen_r, pin_r} <= {1'b1, wdata & PMSK};
        end
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {baud_seen_r, baud_r} <= 9'h000;
        end else if (wr && baud_hit) begin
            {baud_seen_r, baud_r} <= {1'b1, wdata & BMSK};
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_pin_reset: assert property (
        rd && pin_hit && !pin_seen_r |-> rdata == 8'h00)
        else $error("pin function register not at reset value");
    a_baud_reset: assert property (
        rd && baud_hit && !baud_seen_r |-> rdata == 8'h1f)
        else $error("baud control register not at reset value");
    a_pin_unused_zero: assert property (
        rd && pin_hit |-> (rdata & ~PMSK) == 8'h00)
        else $error("unused pin register bit reads one");
    a_baud_unused_zero: assert property (
        rd && baud_hit |-> (rdata & ~BMSK) == 8'h00)
        else $error("unused baud register bit reads one");
    a_unmapped_zero: assert property (
        rd && !pin_hit && !baud_hit |-> rdata == 8'h00)
        else $error("unmapped read is not zero");
    a_pin_readback: assert property (
        rd && pin_hit && pin_seen_r |-> rdata == pin_r)
        else $error("pin register lost a write");
    a_baud_readback: assert property (
        rd && baud_hit && baud_seen_r |-> rdata == baud_r)
        else $error("baud register lost a write");
    a_write_single: assert property (
        wr |=> !wr && !rd)
        else $error("write strobe longer than one cycle");
endmodule
`default_nettype wire

// File: test/uart_baud_rate_generator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_baud_rate_generator_bench;
    localparam logic [15:0] PIN = baud_gen_pkg::TX_PIN_FUNCTION_SELECT_OFS;
    localparam logic [15:0] BAUD = baud_gen_pkg::BAUD_CLOCK_CONTROL_OFS;
    logic mclk = 0, nrst = 0, av_rd = 0, av_wr = 0, av_wait, refused;
    logic [3:0] av_addr = 0, tcnt = 0;
    logic [31:0] av_wd = 0, av_q, av_res;
    logic pwr = 0, txe = 0, rxe = 0, tmr = 0, tx_a = 1, tx_b = 1, gpl = 0;
    logic bt, tx_s, rx_s, bad, pin, btk, bclk;
    int mismatches = 0, num_checks = 0, cycles = 0;
    baud_gen_if link ();
    baud_gen_host baud_gen_host_i (.mclk_i(mclk), .nrst_i(nrst),
        .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wd), .avs_readdata_o(av_q),
        .avs_waitrequest_o(av_wait), .power_enable_i(pwr),
        .transmit_enable_bit_i(txe), .receive_enable_bit_i(rxe),
        .regs(link.host));
    baud_gen_device baud_gen_device_i (.mclk_i(mclk), .nrst_i(nrst),
        .regs(link.device), .timer_output_source_i(tmr),
        .transmit_enable_bit_i(txe), .receive_enable_bit_i(rxe),
        .serial_tx_a_i(tx_a), .serial_tx_b_i(tx_b),
        .general_port_line_i(gpl), .base_clk_tick_o(btk), .baud_tick_o(bt),
        .baud_clk_o(bclk), .tx_enable_sync_o(tx_s), .rx_enable_sync_o(rx_s),
        .divisor_illegal_o(bad), .shared_pin_o(pin));
    baud_gen_properties baud_gen_properties_i (.mclk_i(mclk),
        .nrst_i(nrst), .addr(link.addr), .wr(link.wr), .rd(link.rd),
        .wdata(link.wdata), .rdata(link.rdata));

    always #20 mclk = ~mclk;
    // Timer stand-in with a sixteen-cycle period, plus the hang limit
    always @(posedge mclk) begin
        tcnt <= tcnt + 4'h1;
        tmr <= tcnt[3]; // running from the start, 50% duty
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic chk_n(input int got, exp, input string m);
        num_checks++;
        if (got != exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s %0d/%0d", $time, m, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One Avalon transfer; held until waitrequest is seen low
    task automatic av(input logic [3:0] a, input logic w, logic [31:0] d);
        @(posedge mclk);
        {av_addr, av_wr, av_rd, av_wd} <= {a, w, !w, d};
        do @(posedge mclk); while (av_wait !== 1'b0);
        av_res = av_q;
        {av_wr, av_rd} <= 2'b00;
    endtask
    // Device access through the host; busy poll is bounded
    task automatic dev(input logic [15:0] a, input logic w, logic [7:0] d);
        int n;
        n = 0;
        av(baud_gen_pkg::CTL_ADDR_OFS, 1, {16'h0, a});
        av(baud_gen_pkg::CTL_WDATA_OFS, 1, {24'h0, d});
        av(baud_gen_pkg::CTL_CMD_OFS, 1, w ? 32'h1 : 32'h2);
        do begin
            av(baud_gen_pkg::CTL_STATUS_OFS, 0, 32'h0);
            n++;
        end while (av_res[0] !== 1'b0 && n < 20);
        if (av_res[0] !== 1'b0) begin
            mismatches++;
            $display("CHECK FAILED %0t busy never cleared", $time);
        end
        refused = av_res[1];
        av(baud_gen_pkg::CTL_RDATA_OFS, 0, 32'h0);
    endtask
    // Edges from one baud tick to the next, the first interval skipped
    task automatic meas(output int p);
        p = 0;
        repeat (2) @(posedge mclk iff bt === 1'b1);
        do begin @(posedge mclk); p++; end while (bt !== 1'b1);
    endtask
    function automatic int exp_per(input logic [1:0] s, input int k);
        return 2 * k * (s == 2'h0 ? 16 : s == 2'h1 ? 2 : s == 2'h2 ? 8 : 32);
    endfunction

    initial begin
        logic [7:0] d;
        int p, k;
        void'($urandom(67));
        repeat (8) @(posedge mclk);
        nrst <= 1;
        dev(BAUD, 0, 0); chk(av_res[7:0], 8'h1f, "baud reset");
        dev(PIN, 0, 0); chk(av_res[7:0], 8'h00, "pin reset");
        dev(PIN, 1, 8'hff); dev(PIN, 0, 0); chk(av_res[7:0], 8'h08, "pin");
        dev(16'h1234, 1, 8'h5a); dev(16'h1234, 0, 0);
        chk(av_res[7:0], 8'h00, "unmapped");
        repeat (4) begin
            d = 8'($urandom);
            dev(BAUD, 1, d); dev(BAUD, 0, 0); chk(av_res[7:0], d & 8'hdf, "b");
        end
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            k = s == 0 ? 8 : s == 3 ? 31 : 9 + $urandom % 22;
            dev(BAUD, 1, {s[1:0], 1'b0, k[4:0]});
            meas(p); chk_n(p, exp_per(s[1:0], k), "period");
            chk({7'h0, bclk}, 8'h01, "baud clk");
            if (s != 0) begin
                p = 0;
                repeat (64) begin @(posedge mclk); p += btk; end
                chk_n(p, 128 / exp_per(s[1:0], 1), "base");
            end
        end
        dev(BAUD, 1, 8'h47); chk({7'h0, bad}, 8'h01, "k 7");
        dev(BAUD, 1, 8'h48); chk({7'h0, bad}, 8'h00, "k 8");
        $display("test rates done");
        for (int i = 0; i < 2; i++) begin
            {txe, rxe} <= i ? 2'b01 : 2'b10;
            dev(BAUD, 1, 8'h49); chk({7'h0, refused}, 8'h01, "en");
            dev(BAUD, 0, 0); chk(av_res[7:0], 8'h48, "kept");
        end
        {txe, rxe, pwr} <= 3'b001;
        dev(BAUD, 1, 8'h88); chk({7'h0, refused}, 8'h01, "pwr");
        dev(BAUD, 1, 8'h4c); dev(BAUD, 0, 0); chk(av_res[7:0], 8'h4c, "k");
        pwr <= 0;
        $display("test refusals done");
        {txe, rxe} <= 2'b11;
        @(posedge mclk); #1 chk({6'h0, tx_s, rx_s}, 8'h00, "early");
        repeat (10) @(posedge mclk); chk({6'h0, tx_s, rx_s}, 8'h03, "on");
        {txe, rxe} <= 2'b00;
        repeat (10) @(posedge mclk); chk({6'h0, tx_s, rx_s}, 8'h00, "off");
        $display("test enables done");
        dev(PIN, 1, 8'h08);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) dev(PIN, 1, 8'h00);
            {tx_a, tx_b, gpl} <= 3'($urandom);
            repeat (2) @(posedge mclk);
            chk({7'h0, pin}, {7'h0, i < 4 ? tx_a & tx_b : gpl}, "pin");
        end
        $display("test routing done");
        end_sim();
    end
endmodule
`default_nettype wire
